// ### hw/tkcst_consts.vh
// Constants for the touch-sense cycle timer
`ifndef TKCST_CONSTS_VH
`define TKCST_CONSTS_VH

`define TKCST_ADDR_CONTROL 8'hc3
`define TKCST_ADDR_COUNT_LOW 8'hc4
`define TKCST_ADDR_COUNT_HIGH 8'hc5

`define TKCST_BIT_DONE 7
`define TKCST_BIT_LENGTH 4
`define TKCST_CHAN_MSB 2
`define TKCST_CHAN_LSB 0
`define TKCST_BIT_CHANGED 15

`define TKCST_CONTROL_RESET 8'h00
`define TKCST_COUNT_HIGH_RESET 8'h00

`define TKCST_CHAN_OFF 3'h0
`define TKCST_CHAN_FIRST 3'h1
`define TKCST_CHAN_LAST 3'h6
`define TKCST_CHAN_FLOAT 3'h7

`define TKCST_OSC_MHZ 24
`define TKCST_CYCLE_SHORT_US 1000
`define TKCST_CYCLE_LONG_US 2000
`define TKCST_PREP_US 87
`define TKCST_CYCLE_SHORT_CLKS (`TKCST_CYCLE_SHORT_US * `TKCST_OSC_MHZ)
`define TKCST_CYCLE_LONG_CLKS (`TKCST_CYCLE_LONG_US * `TKCST_OSC_MHZ)
`define TKCST_PREP_CLKS (`TKCST_PREP_US * `TKCST_OSC_MHZ)

`define TKCST_COUNT_WIDTH 14
`define TKCST_TIMER_WIDTH 16

`endif

// ### hw/tkcst_timer.v
// Touch-sense cycle timer with control and count registers
`timescale 1ns/1ns
`default_nettype none
`include "tkcst_consts.vh"

module tkcst_timer #(
	parameter [15:0] CYCLE_SHORT_CLKS = `TKCST_CYCLE_SHORT_CLKS,
	parameter [15:0] CYCLE_LONG_CLKS = `TKCST_CYCLE_LONG_CLKS
) (
	input wire clk,
	input wire reset_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [15:0] reg_rdata,
	input wire [5:0] sense_input,
	output wire [5:0] sense_connect,
	output wire sense_power,
	output wire detect_active,
	output wire irq
);

	// Stage codes and fixed constants
	localparam STATE_PREP = 1'b0;
	localparam STATE_DETECT = 1'b1;
	localparam [15:0] PREP_CLKS = `TKCST_PREP_CLKS;
	localparam [7:0] CONTROL_RESET = `TKCST_CONTROL_RESET;
	localparam [`TKCST_COUNT_WIDTH-1:0] COUNT_ZERO = {`TKCST_COUNT_WIDTH{1'b0}};
	localparam [`TKCST_COUNT_WIDTH-1:0] COUNT_ONE = {{(`TKCST_COUNT_WIDTH-1){1'b0}}, 1'b1};
	localparam [`TKCST_COUNT_WIDTH-1:0] COUNT_FULL = {`TKCST_COUNT_WIDTH{1'b1}};
	localparam [15:0] TIMER_ZERO = 16'h0000;
	localparam [15:0] TIMER_STEP = 16'h0001;

	// True when a channel code selects one of the six sense inputs
	function chan_valid;
		input [2:0] code;
		begin
			chan_valid = (code >= `TKCST_CHAN_FIRST) && (code <= `TKCST_CHAN_LAST);
		end
	endfunction

	// One-hot connect mask for a channel code; codes 0 and 7 connect nothing
	function [5:0] chan_mask;
		input [2:0] code;
		reg [2:0] index;
		begin
			index = code - `TKCST_CHAN_FIRST;
			if (chan_valid(code)) begin
				chan_mask = 6'h01 << index;
			end else begin
				chan_mask = 6'h00;
			end
		end
	endfunction

	// Register address match, shared by the write and read paths
	function addr_is;
		input [7:0] addr;
		input [7:0] target;
		begin
			addr_is = (addr == target);
		end
	endfunction

	// Control byte as software reads it; reserved bits read as zero
	function [7:0] control_byte;
		input done;
		input length;
		input [2:0] channel;
		begin
			control_byte = 8'h00;
			control_byte[`TKCST_BIT_DONE] = done;
			control_byte[`TKCST_BIT_LENGTH] = length;
			control_byte[`TKCST_CHAN_MSB:`TKCST_CHAN_LSB] = channel;
		end
	endfunction

	// Saturating increment, so a stuck input cannot wrap the reading to a small value
	function [`TKCST_COUNT_WIDTH-1:0] count_step;
		input [`TKCST_COUNT_WIDTH-1:0] value;
		begin
			if (value == COUNT_FULL) begin
				count_step = value;
			end else begin
				count_step = value + COUNT_ONE;
			end
		end
	endfunction

	// State
	reg state;
	reg [15:0] timer;
	reg length_select;
	reg [2:0] channel_select;
	reg cycle_done_flag;
	reg control_changed_flag;
	reg [`TKCST_COUNT_WIDTH-1:0] count;

	// Decoded conditions
	wire control_write;
	wire read_control;
	wire read_count_low;
	wire read_count_high;
	wire in_prep;
	wire in_detect;
	wire [15:0] cycle_clks;
	wire [15:0] prep_last;
	wire [15:0] cycle_last;
	wire prep_end;
	wire cycle_end;
	wire [5:0] mask;
	wire sense_hit;
	wire [15:0] count_word;
	wire [7:0] control_view;

	// Next-state values
	reg next_state;
	reg [15:0] next_timer;
	reg next_done;
	reg next_changed;
	reg [`TKCST_COUNT_WIDTH-1:0] next_count;
	reg [15:0] next_rdata;

	// Address decode
	assign control_write = reg_write && addr_is(reg_addr, `TKCST_ADDR_CONTROL);
	assign read_control = addr_is(reg_addr, `TKCST_ADDR_CONTROL);
	assign read_count_low = addr_is(reg_addr, `TKCST_ADDR_COUNT_LOW);
	assign read_count_high = addr_is(reg_addr, `TKCST_ADDR_COUNT_HIGH);

	// Stage decode
	assign in_prep = (state == STATE_PREP);
	assign in_detect = (state == STATE_DETECT);

	// Nominal times hold only when clk runs at the 24 MHz reference
	assign cycle_clks = length_select ? CYCLE_LONG_CLKS : CYCLE_SHORT_CLKS;
	assign prep_last = PREP_CLKS - TIMER_STEP;
	assign cycle_last = cycle_clks - TIMER_STEP;
	assign prep_end = in_prep && (timer >= prep_last);
	// A shortened length mid-cycle ends the cycle at once rather than wrapping
	assign cycle_end = in_detect && (timer >= cycle_last);

	// Sense input selection
	assign mask = chan_mask(channel_select);
	assign sense_power = (channel_select != `TKCST_CHAN_OFF);
	assign detect_active = in_detect && sense_power;
	assign sense_hit = |(mask & sense_input);

	// Software view
	assign irq = cycle_done_flag;
	assign count_word = {control_changed_flag, 1'b0, count};
	assign control_view = control_byte(cycle_done_flag, length_select, channel_select);

	// Connect only a powered, selected input
	genvar i;
	generate
		for (i = 0; i < 6; i = i + 1) begin : g_connect
			assign sense_connect[i] = mask[i] && sense_power;
		end
	endgenerate

	// Stage sequencer: preparation, then detection, then back
	always @* begin
		next_state = state;
		next_timer = timer + TIMER_STEP;
		case (state)
			STATE_PREP: begin
				if (prep_end) begin
					next_state = STATE_DETECT;
					// Timer carries on so both stages sum to one full cycle
					next_timer = PREP_CLKS;
				end
			end
			STATE_DETECT: begin
				if (cycle_end) begin
					next_state = STATE_PREP;
					next_timer = TIMER_ZERO;
				end
			end
			default: begin
				next_state = STATE_PREP;
				next_timer = TIMER_ZERO;
			end
		endcase
	end

	// Done and change flags
	always @* begin
		next_done = cycle_done_flag;
		next_changed = control_changed_flag;
		if (control_write) begin
			next_done = 1'b0;
		end
		if (control_write && in_detect) begin
			next_changed = 1'b1;
		end
		if (prep_end) begin
			next_done = 1'b0;
			next_changed = 1'b0;
		end else if (cycle_end) begin
			// Event wins over a control write landing in the same cycle
			if (!control_changed_flag) begin
				next_done = 1'b1;
			end else begin
				next_done = 1'b0;
			end
		end
	end

	// Measurement count; the cycle's last clock is not counted
	always @* begin
		next_count = count;
		if (prep_end) begin
			next_count = COUNT_ZERO;
		end else if (in_detect && !cycle_end && sense_hit) begin
			next_count = count_step(count);
		end
	end

	// Read data stand one cycle only; count bytes have no write path at all
	always @* begin
		next_rdata = 16'h0000;
		if (reg_read) begin
			if (read_control) begin
				next_rdata = {8'h00, control_view};
			end else if (read_count_low) begin
				next_rdata = count_word;
			end else if (read_count_high) begin
				next_rdata = {8'h00, count_word[15:8]};
			end
		end
	end

	// Stage and timer registers
	always @(posedge clk) begin
		if (!reset_n) begin
			state <= STATE_PREP;
			timer <= TIMER_ZERO;
		end else begin
			state <= next_state;
			timer <= next_timer;
		end
	end

	// Flag registers
	always @(posedge clk) begin
		if (!reset_n) begin
			cycle_done_flag <= 1'b0;
			control_changed_flag <= 1'b0;
		end else begin
			cycle_done_flag <= next_done;
			control_changed_flag <= next_changed;
		end
	end

	// High byte resets to zero: change flag and upper count bits both clear
	always @(posedge clk) begin
		if (!reset_n) begin
			count <= COUNT_ZERO;
		end else begin
			count <= next_count;
		end
	end

	// Control register
	always @(posedge clk) begin
		if (!reset_n) begin
			length_select <= CONTROL_RESET[`TKCST_BIT_LENGTH];
			channel_select <= CONTROL_RESET[`TKCST_CHAN_MSB:`TKCST_CHAN_LSB];
		end else if (control_write) begin
			// Bit 7 and reserved bits are dropped so software cannot set the flag
			length_select <= reg_wdata[`TKCST_BIT_LENGTH];
			channel_select <= reg_wdata[`TKCST_CHAN_MSB:`TKCST_CHAN_LSB];
		end
	end

	// Read data register
	always @(posedge clk) begin
		if (!reset_n) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

endmodule // tkcst_timer
`default_nettype wire

// ### verification/tkcst_timer_properties.sv
// Checker for the touch-sense cycle timer
`timescale 1ns/1ns
`default_nettype none
module tkcst_timer_chk (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic [5:0] sense_connect,
	input wire logic sense_power,
	input wire logic detect_active,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_prep;
		!detect_active [*8];
	endsequence
	a_done_at_end: assert property (
		$rose(irq) && $past(sense_power) |-> $past(detect_active)) else $error("irq off cycle end");
	a_write_clears: assert property (
		reg_write && reg_addr == 8'hc3 && sense_power && !detect_active |=> !irq)
		else $error("control write left irq set");
	a_prep_clears: assert property (
		$fell(irq) && sense_power && !$past(reg_write) |-> $rose(detect_active))
		else $error("irq fell off prep end");
	a_prep_first: assert property ($rose(irq) |-> s_prep)
		else $error("no preparation after cycle end");
	a_irq_read: assert property (
		reg_read && reg_addr == 8'hc3 |=> reg_rdata[7] == $past(irq) && reg_rdata[15:8] == 8'h00)
		else $error("control readback wrong");
	a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
		else $error("read data outside its cycle");
	a_detect_power: assert property (detect_active |-> sense_power)
		else $error("detecting while unpowered");
	a_one_input: assert property (
		$onehot0(sense_connect) && (sense_connect == 6'h00 || sense_power))
		else $error("bad input connect");
endmodule // tkcst_timer_chk
bind tkcst_timer tkcst_timer_chk chk (.clk, .reset_n, .reg_addr, .reg_write, .reg_read,
	.reg_rdata, .sense_connect, .sense_power, .detect_active, .irq);
`default_nettype wire

// ### verification/tb.sv
// Testbench for the touch-sense cycle timer
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk = 0, reset_n = 0, wr = 0, rd = 0, pwr, det, irq;
	logic [7:0] ad = 0, wd = 0;
	logic [15:0] rdata;
	logic [5:0] sin = 6'h01, con;
	logic [6:0] e;
	int num_errors = 0, n_tests = 0, n;
	// Short cycles keep the run brief; preparation stays 2088 clocks
	tkcst_timer #(.CYCLE_SHORT_CLKS(16'd3000), .CYCLE_LONG_CLKS(16'd5000)) dut (.clk(clk),
		.reset_n(reset_n), .reg_addr(ad), .reg_wdata(wd), .reg_write(wr), .reg_read(rd),
		.reg_rdata(rdata), .sense_input(sin), .sense_connect(con), .sense_power(pwr),
		.detect_active(det), .irq(irq));
	initial forever #5 clk = ~clk;
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("errors=%0d checks=%0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1;
		ad <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
	endtask
	task rd_reg(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		rd <= 1;
		ad <= a;
		@(posedge clk);
		rd <= 0;
		#1 chk(rdata, exp);
	endtask
	// Counts edges until irq (0), detection (1) or irq low (2); bounded
	task wt(input int s, input int lim);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (!(s == 0 ? irq : s == 1 ? det : !irq) && n < lim);
		if (n >= lim) begin
			num_errors++;
			finish_test;
		end
	endtask
	initial begin
		repeat (12) @(posedge clk);
		reset_n <= 1;
		rd_reg(8'hc3, 16'h0000);
		rd_reg(8'h10, 16'h0000);
		wr_reg(8'hc5, 8'hff);
		rd_reg(8'hc5, 16'h0000);
		wr_reg(8'hc3, 8'hff);
		rd_reg(8'hc3, 16'h0017);
		for (int c = 0; c < 8; c++) begin
			wr_reg(8'hc3, c[7:0]);
			e = (c > 0 && c < 7) ? 7'h01 << (c - 1) : 7'h00;
			e[6] = c != 0;
			#1 chk({9'h000, pwr, con}, {9'h000, e});
		end
		wr_reg(8'hc3, 8'h01);
		wt(0, 4000);
		rd_reg(8'hc4, 16'h038f);
		rd_reg(8'hc5, 16'h0003);
		wr_reg(8'hc3, 8'h01);
		wt(2, 2);
		wt(1, 3000);
		wt(0, 1000);
		chk(n[15:0], 16'd912);
		wt(1, 3000);
		chk(n[15:0], 16'd2088);
		wr_reg(8'hc3, 8'h01);
		rd_reg(8'hc5, 16'h0080);
		wt(0, 5000);
		chk(n[15:0], 16'd3908);
		wr_reg(8'hc3, 8'h11);
		wt(1, 3000);
		wt(0, 4000);
		chk(n[15:0], 16'd2912);
		wr_reg(8'hc3, 8'h00);
		wt(2, 3000);
		wt(0, 4000);
		chk(n[15:0], 16'd2997);
		finish_test;
	end
endmodule // tb
`default_nettype wire
